/* rtl/pmic_startup_timing_control.sv */
`timescale 1ns/100ps
`default_nettype none
module pmic_startup_timing_control
    import startup_timing_pkg::*;
#(
    parameter int unsigned FUSE_CYC  = FUSE_LOAD_CYC,
    parameter int unsigned TEST_CYC  = SELF_TEST_CYC,
    parameter int unsigned FIRST_CYC = FIRST_SLOT_CYC,
    parameter int unsigned R2R_CYC   = REG2RESET_CYC,
    parameter int unsigned SLOT_T    = SLOT_CYC,
    parameter int unsigned DB_CYC    = DBNC_CYC
) (
    input  wire logic       clk_sys,
    input  wire logic       rst_b,
    input  wire logic       power_on_request,
    input  wire logic       power_on_pin_mode,
    input  wire logic       lpoff_wr_en,
    input  wire logic       lpoff_wr_data,
    input  wire logic [7:0] reg_slot,
    input  wire logic [7:0] reset_slot,
    output logic            low_power_off_sel,
    output logic            low_power_off_state,
    output logic            fuse_load_done,
    output logic            self_test_done,
    output logic            circuits_en,
    output logic            reg_en,
    output logic            host_reset_out,
    output logic            run_mode
);
    state_t           st_r, st_nxt;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    logic [CNT_W-1:0] r2r_r, r2r_nxt;
    logic [7:0]       slot_r, slot_nxt;
    logic             lpsel_r, lpsel_nxt;
    logic             fuse_r, fuse_nxt;
    logic             test_r, test_nxt;
    logic             reg_r, reg_nxt;
    logic             rst_out_r, rst_out_nxt;
    logic             req_d_r;
    logic             last_slot;
    logic [7:0]       final_slot;

    // reset pin without a slot follows the last regulator
    assign final_slot = (reset_slot == SLOT_OFF) ? reg_slot : reset_slot;
    assign last_slot  = (slot_r >= final_slot);
    // slot codes past the final one are never reached, except slot 1 when the final slot is 0

    // state-derived port values, registered below so every port leaves a flip-flop
    logic             lp_state_nxt;
    logic             circ_nxt;
    logic             run_nxt;

    always_comb begin
        lp_state_nxt = 1'b0;
        circ_nxt     = 1'b0;
        run_nxt      = 1'b0;
        case (st_nxt)
            ST_LPOFF, ST_DBNC: begin
                lp_state_nxt = 1'b1;
            end
            ST_TEST, ST_FIRST, ST_SEQ: begin
                circ_nxt = 1'b1;
            end
            ST_RUN: begin
                circ_nxt = 1'b1;
                run_nxt  = 1'b1;
            end
            default: begin
                lp_state_nxt = 1'b0;
            end
        endcase
    end

    always_comb begin
        st_nxt      = st_r;
        cnt_nxt     = cnt_r + 16'h0001;
        r2r_nxt     = r2r_r;
        slot_nxt    = slot_r;
        lpsel_nxt   = lpsel_r;
        fuse_nxt    = fuse_r;
        test_nxt    = test_r;
        reg_nxt     = reg_r;
        rst_out_nxt = rst_out_r;
        case (st_r)
            ST_FUSE: begin
                // request is not looked at until fuses are loaded
                if (cnt_r >= CNT_W'(FUSE_CYC - 1)) begin
                    fuse_nxt = 1'b1;
                    st_nxt   = ST_LPOFF;
                    cnt_nxt  = '0;
                end
            end
            ST_LPOFF: begin
                cnt_nxt = '0;
                // stays here with circuits off while request is inactive
                // level mode looks at the pin each cycle; edge mode needs a fall
                if (power_on_pin_mode == MODE_LEVEL && power_on_request) begin
                    st_nxt = ST_TEST;
                end else if (power_on_pin_mode == MODE_EDGE && req_d_r && !power_on_request) begin
                    st_nxt = ST_DBNC;
                end
            end
            ST_DBNC: begin
                // any rise during debounce restarts the wait from low-power off
                if (power_on_request) begin
                    st_nxt  = ST_LPOFF;
                end else if (cnt_r >= CNT_W'(DB_CYC - 1)) begin
                    st_nxt  = ST_TEST;
                    cnt_nxt = '0;
                end
            end
            ST_TEST: begin
                // circuits come up with the test, so this path is the slow one
                if (cnt_r >= CNT_W'(TEST_CYC - 1)) begin
                    test_nxt = 1'b1;
                    st_nxt   = ST_FIRST;
                    cnt_nxt  = '0;
                end
            end
            ST_FIRST: begin
                // both done flags gate the sequencer, even if fuse load ran long
                if (fuse_r && test_r && cnt_r >= CNT_W'(FIRST_CYC - 1)) begin
                    st_nxt   = ST_SEQ;
                    cnt_nxt  = '0;
                    slot_nxt = 8'h01;
                end
            end
            ST_SEQ: begin
                // saturates so a long programmed sequence cannot wrap the span
                if (reg_r && r2r_r != {CNT_W{1'b1}}) begin
                    r2r_nxt = r2r_r + 16'h0001;
                end
                if (reg_slot != SLOT_OFF && slot_r == reg_slot) begin
                    reg_nxt = 1'b1;
                end
                if (cnt_r >= CNT_W'(SLOT_T - 1)) begin
                    cnt_nxt = '0;
                    // host reset released only once the final slot has run out
                    if (last_slot) begin
                        st_nxt      = ST_RUN;
                        rst_out_nxt = 1'b1;
                    end else begin
                        slot_nxt = slot_r + 8'h01;
                    end
                end
            end
            ST_RUN: begin
                // write pulses outside run are dropped on purpose
                cnt_nxt = '0;
                if (lpoff_wr_en) begin
                    lpsel_nxt = lpoff_wr_data;
                end
            end
            default: begin
                st_nxt = ST_FUSE;
            end
        endcase
    end

    // supply threshold crossing modelled by rst_b; select bit only survives within one power cycle
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            // counters restart each power cycle
            st_r      <= ST_FUSE;
            cnt_r     <= '0;
            r2r_r     <= '0;
            slot_r    <= 8'h00;
            lpsel_r   <= LPOFF_RESET;
            fuse_r    <= 1'b0;
            test_r    <= 1'b0;
            reg_r     <= 1'b0;
            rst_out_r <= 1'b0;
            // cleared low so no false fall is seen right after release
            req_d_r   <= 1'b0;
        end else begin
            st_r      <= st_nxt;
            cnt_r     <= cnt_nxt;
            r2r_r     <= r2r_nxt;
            slot_r    <= slot_nxt;
            lpsel_r   <= lpsel_nxt;
            fuse_r    <= fuse_nxt;
            test_r    <= test_nxt;
            reg_r     <= reg_nxt;
            rst_out_r <= rst_out_nxt;
            req_d_r   <= power_on_request;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            low_power_off_sel   <= 1'b0;
            low_power_off_state <= 1'b0;
            fuse_load_done      <= 1'b0;
            self_test_done      <= 1'b0;
            circuits_en         <= 1'b0;
            reg_en              <= 1'b0;
            host_reset_out      <= 1'b0;
            run_mode            <= 1'b0;
        end else begin
            low_power_off_sel   <= lpsel_nxt;
            low_power_off_state <= lp_state_nxt;
            fuse_load_done      <= fuse_nxt;
            self_test_done      <= test_nxt;
            circuits_en         <= circ_nxt;
            reg_en              <= reg_nxt;
            host_reset_out      <= rst_out_nxt;
            run_mode            <= run_nxt;
        end
    end
endmodule // pmic_startup_timing_control
`default_nettype wire

/* rtl/startup_timing_pkg.sv */
package startup_timing_pkg;
    localparam int unsigned CLK_HZ          = 20_000_000;
    localparam int unsigned FUSE_LOAD_US    = 600;
    localparam int unsigned SELF_TEST_US    = 700;
    localparam int unsigned FIRST_SLOT_US   = 100;
    localparam int unsigned REG2RESET_US    = 1500;
    localparam int unsigned FUSE_LOAD_CYC   = FUSE_LOAD_US * (CLK_HZ / 1_000_000);
    localparam int unsigned SELF_TEST_CYC   = SELF_TEST_US * (CLK_HZ / 1_000_000);
    localparam int unsigned FIRST_SLOT_CYC  = FIRST_SLOT_US * (CLK_HZ / 1_000_000);
    localparam int unsigned REG2RESET_CYC   = REG2RESET_US * (CLK_HZ / 1_000_000);
    localparam int unsigned DBNC_CYC        = 640;
    localparam int unsigned SLOT_CYC        = 600;
    localparam int unsigned CNT_W           = 16;
    localparam logic        LPOFF_RESET     = 1'b0;
    localparam logic [7:0]  SLOT_OFF        = 8'h00;
    localparam logic        MODE_LEVEL      = 1'b0;
    localparam logic        MODE_EDGE       = 1'b1;

    typedef enum logic [6:0] {
        ST_FUSE   = 7'b0000001,
        ST_LPOFF  = 7'b0000010,
        ST_DBNC   = 7'b0000100,
        ST_TEST   = 7'b0001000,
        ST_FIRST  = 7'b0010000,
        ST_SEQ    = 7'b0100000,
        ST_RUN    = 7'b1000000
    } state_t;
endpackage

/* tb/pmic_startup_timing_control_checker.sv */
`timescale 1ns/100ps
`default_nettype none
module pmic_startup_timing_control_checker
    import startup_timing_pkg::*;
#(
    parameter int FUSE_CYC  = 8,
    parameter int TEST_CYC  = 10,
    parameter int FIRST_CYC = 4
) (
    input wire logic       clk_sys,
    input wire logic       rst_b,
    input wire logic       power_on_request,
    input wire logic       power_on_pin_mode,
    input wire logic       lpoff_wr_en,
    input wire logic       lpoff_wr_data,
    input wire logic [7:0] reg_slot,
    input wire logic       low_power_off_sel,
    input wire logic       low_power_off_state,
    input wire logic       fuse_load_done,
    input wire logic       self_test_done,
    input wire logic       circuits_en,
    input wire logic       reg_en,
    input wire logic       host_reset_out,
    input wire logic       run_mode
);
    localparam int FUSE_MAX  = FUSE_CYC + 1;
    localparam int TEST_MAX  = TEST_CYC + 2;
    localparam int FIRST_MAX = FIRST_CYC + 3;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    AST_FUSE_TIME: assert property ($rose(rst_b) |-> ##[1:FUSE_MAX] fuse_load_done)
        else $error("fuse load late");
    AST_STAY_OFF: assert property (low_power_off_state && !power_on_request
        && power_on_pin_mode == MODE_LEVEL |=> low_power_off_state && !circuits_en) else $error("left off");
    AST_WAKE: assert property (low_power_off_state && power_on_request
        && power_on_pin_mode == MODE_LEVEL |=> circuits_en && !low_power_off_state) else $error("no wake");
    AST_ORDER: assert property ($rose(self_test_done) |-> circuits_en && fuse_load_done && !reg_en)
        else $error("test out of order");
    AST_TEST_TIME: assert property ($rose(circuits_en) |-> ##[1:TEST_MAX] self_test_done)
        else $error("self test late");
    AST_FIRST: assert property ($rose(self_test_done) && reg_slot == 8'h01 |-> ##[1:FIRST_MAX] reg_en)
        else $error("first slot late");
    AST_SLOT_OFF: assert property (reg_slot == SLOT_OFF && !reg_en |=> !reg_en)
        else $error("excluded output on");
    AST_SEL_HOLD: assert property (!run_mode |=> $stable(low_power_off_sel))
        else $error("select bit moved");
    AST_SEL_WR: assert property (run_mode && lpoff_wr_en |=> low_power_off_sel == $past(lpoff_wr_data))
        else $error("select write lost");
    AST_RELEASE: assert property (host_reset_out |-> run_mode && self_test_done)
        else $error("early host release");
    cover property ($rose(host_reset_out));
    cover property ($rose(reg_en));
    cover property (run_mode && lpoff_wr_en);
endmodule // pmic_startup_timing_control_checker
bind pmic_startup_timing_control pmic_startup_timing_control_checker #(
    .FUSE_CYC(FUSE_CYC), .TEST_CYC(TEST_CYC), .FIRST_CYC(FIRST_CYC)) i_chk (.*);
`default_nettype wire

/* tb/pmic_startup_timing_control_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module pmic_startup_timing_control_tb;
    import startup_timing_pkg::*;
    logic clk_sys, rst_b, go, power_on_pin_mode, lpoff_wr_en, lpoff_wr_data, power_on_request;
    logic low_power_off_sel, low_power_off_state, fuse_load_done, self_test_done;
    logic circuits_en, reg_en, host_reset_out, run_mode;
    logic [7:0] reg_slot, reset_slot;
    int fails, n_checks;
    startup_host_model i_host (.clk_sys(clk_sys), .go(go), .edge_md(power_on_pin_mode),
        .power_on_request(power_on_request));
    // short counts keep the run small
    pmic_startup_timing_control #(.FUSE_CYC(8), .TEST_CYC(10), .FIRST_CYC(4), .R2R_CYC(20),
        .SLOT_T(5), .DB_CYC(6)) i_dut (.*);
    task automatic chk(input logic got, input logic exp);
        #1;
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic boot(input logic md, input logic [7:0] rs);
        power_on_pin_mode <= md;
        reg_slot <= rs;
        go <= 1'b0;
        rst_b <= 1'b0;
        repeat (16) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (30) @(posedge clk_sys);
        lpoff_wr_en <= 1'b1;
        @(posedge clk_sys);
        lpoff_wr_en <= 1'b0;
        @(posedge clk_sys);
        chk(low_power_off_state, 1'b1);
        chk(low_power_off_sel, LPOFF_RESET);
        @(posedge clk_sys);
        go <= 1'b1;
        for (int i = 0; i < 200 && run_mode !== 1'b1; i++) @(posedge clk_sys);
        chk(host_reset_out, 1'b1);
        chk(reg_en, rs != SLOT_OFF);
    endtask
    task automatic t_write();
        reset_slot <= 8'h03;
        boot(MODE_LEVEL, 8'h02);
        for (int k = 0; k < 3; k++) begin
            lpoff_wr_data <= (k != 1);
            lpoff_wr_en <= 1'b1;
            @(posedge clk_sys);
            lpoff_wr_en <= 1'b0;
            repeat (3) @(posedge clk_sys);
            chk(low_power_off_sel, k != 1);
        end
        @(posedge clk_sys);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk_sys);
        chk(low_power_off_sel, LPOFF_RESET);
    endtask
    task automatic stop_test();
        $display("fails=%0d n_checks=%0d", fails, n_checks);
        if (fails == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    initial begin
        {rst_b, go, power_on_pin_mode, lpoff_wr_en} = 4'h0;
        lpoff_wr_data = 1'b1;
        reg_slot = 8'h01;
        reset_slot = 8'h00;
        fails = 0;
        n_checks = 0;
        boot(MODE_LEVEL, 8'h01);
        boot(MODE_EDGE, 8'h01);
        boot(MODE_LEVEL, SLOT_OFF);
        t_write();
        stop_test();
    end
    // about four boots of under a hundred cycles each
    initial begin
        #200000;
        fails++;
        stop_test();
    end
endmodule // pmic_startup_timing_control_tb
`default_nettype wire

/* tb/startup_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module startup_host_model (
    input  wire logic clk_sys,
    input  wire logic go,
    input  wire logic edge_md,
    output logic      power_on_request
);
    int n;
    initial power_on_request = 1'b0;
    // edge mode: short high, then fall held low well past debounce
    always @(posedge clk_sys) begin
        if (!go) begin
            power_on_request <= 1'b0;
            n <= 0;
        end else if (!edge_md) begin
            power_on_request <= 1'b1;
        end else begin
            n <= n + 1;
            power_on_request <= (n < 3);
        end
    end
endmodule // startup_host_model
`default_nettype wire
